// ==== bcp_commutation_pwm.sv ====
`timescale 1ns/1ns
`include "bcp_map.svh"
// Functional notes
// [R01] Index zero to five selects switching state.
// [R02] Duty is Q15, host keeps it positive.
// [R03] Q15 modulation input scales the period.
// [R04] Period constant defaults to twenty kilohertz.
// [R05] Six full-compare gate outputs, one per switch.
// [R06] Two phases energised, third left unpowered.
// [R07] Exactly two gates active, four off.
// [R08] Upper switch modulated, lower switch fully on.
// [R09] Index 0: switch 1 PWM, 4 on.
// [R10] Index 1: switch 1 PWM, 6 on.
// [R11] Index 2: switch 3 PWM, 6 on.
// [R12] Index 3: switch 3 PWM, 2 on.
// [R13] Index 4: switch 5 PWM, 2 on.
// [R14] Index 5: switch 5 PWM, 4 on.
// [R15] Host initialises before any update.
// [R16] Update request loads compare and action settings.
// [R17] Compare equals duty times active period.
// [R18] Three compare channels feed six outputs.
module bcp_commutation_pwm #(
   parameter int PERIOD_CYC = `BCP_PERIOD_CYC
) (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Inverter gate drives, index 0 is switch 1.
   output logic [5:0]       gate_output_n
);

   if (PERIOD_CYC < 2 || PERIOD_CYC > 65535) begin : g_chk
      $error("PERIOD_CYC must lie between 2 and 65535");
   end

   localparam logic [15:0] PER16 = 16'(PERIOD_CYC);

   // Bus state.
   logic                      wr_q, rd_q, rdy_q;
   logic [7:0]                addr_q;
   logic [31:0]               rdata_q;
   // Software registers.
   logic                      init_q;
   logic [2:0]                idx_q;
   bcp_pkg::bcp_q15_t         duty_q, mfunc_q;
   logic                      upd;
   // Shadow and active settings.
   logic                      pend_q;
   bcp_pkg::bcp_action_control_word_t        sh_action_control_word_q, action_control_word_q;
   logic [15:0]               sh_act_q, act_q, sh_cmp_q;
   logic [15:0]               cmp_q [3];
   logic [2:0]                sh_idx_q, cur_idx_q;
   logic [15:0]               cnt_q;
   logic [5:0]                gate_q;
   bcp_pkg::bcp_mode_t        mode_q;
   // Combinational values.
   logic                      addr_ph, wrap, load;
   logic [31:0]               per_prod, cmp_prod;
   logic [15:0]               act_calc, cmp_calc, duty_pos;
   bcp_pkg::bcp_action_control_word_t        action_control_word_calc;
   logic [31:0]               rmux;
   logic [5:0]                gate_d;

   assign addr_ph = hsel && htrans[1] && hready;
   assign upd     = wr_q && addr_q == `BCP_OFS_UPDATE && hwdata[`BCP_UPD_REQ_BIT];

   // Address phase capture; reads take one wait state so a write just before
   // them is already visible.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         rdy_q  <= 1'b1;
         addr_q <= 8'h00;
      end else begin
         wr_q <= addr_ph && hwrite;
         rd_q <= addr_ph && !hwrite;
         rdy_q <= !(addr_ph && !hwrite);
         if (addr_ph) begin
            addr_q <= {haddr[7:2], 2'b00};
         end
      end
   end

   // Read multiplexer; unmapped offsets read as zero.
   always_comb begin
      rmux = 32'h0;
      unique case (addr_q)
         `BCP_OFS_CTRL:   rmux = {31'h0, init_q};
         `BCP_OFS_STATE:  rmux = {29'h0, idx_q};
         `BCP_OFS_DUTY:   rmux = {16'h0, duty_q};
         `BCP_OFS_MFUNC:  rmux = {16'h0, mfunc_q};
         `BCP_OFS_STATUS: rmux = {16'h0, pend_q, cur_idx_q, action_control_word_q};
         `BCP_OFS_CMP1:   rmux = {16'h0, cmp_q[0]};
         `BCP_OFS_CMP2:   rmux = {16'h0, cmp_q[1]};
         `BCP_OFS_CMP3:   rmux = {16'h0, cmp_q[2]};
         `BCP_OFS_PERIOD: rmux = {16'h0, act_q};
         default:         rmux = 32'h0;
      endcase
   end

   // Read data is registered in the wait-state cycle.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0;
      end else if (rd_q) begin
         rdata_q <= rmux;
      end
   end

   // Software-written registers take hwdata in the data phase.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         init_q  <= 1'b0;
         idx_q   <= `BCP_STATE_RST;
         duty_q  <= `BCP_Q15_RST;
         mfunc_q <= `BCP_MFUNC_RST;
      end else if (wr_q) begin
         unique case (addr_q)
            `BCP_OFS_CTRL:  init_q  <= hwdata[`BCP_CTRL_INIT_BIT];
            // [R01] index register width
            `BCP_OFS_STATE: idx_q   <= hwdata[2:0];
            `BCP_OFS_DUTY:  duty_q  <= hwdata[15:0];
            `BCP_OFS_MFUNC: mfunc_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Mode follows the init bit; clearing it parks the outputs.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= bcp_pkg::BCP_UNINIT;
      end else begin
         unique case (mode_q)
            bcp_pkg::BCP_UNINIT: if (init_q) mode_q <= bcp_pkg::BCP_RUN;
            bcp_pkg::BCP_RUN:    if (!init_q) mode_q <= bcp_pkg::BCP_UNINIT;
         endcase
      end
   end

   // [R09] state table lookup
   // [R06] two phases per state
   // Indexes six and seven are illegal and park every gate low.
   always_comb begin
      unique case (idx_q)
         3'd0:    action_control_word_calc = `BCP_ACTION_CONTROL_WORD_S0;
         3'd1:    action_control_word_calc = `BCP_ACTION_CONTROL_WORD_S1; // [R10] index one
         3'd2:    action_control_word_calc = `BCP_ACTION_CONTROL_WORD_S2; // [R11] index two
         3'd3:    action_control_word_calc = `BCP_ACTION_CONTROL_WORD_S3; // [R12] index three
         3'd4:    action_control_word_calc = `BCP_ACTION_CONTROL_WORD_S4; // [R13] index four
         3'd5:    action_control_word_calc = `BCP_ACTION_CONTROL_WORD_S5; // [R14] index five
         default: action_control_word_calc = `BCP_ACTION_CONTROL_WORD_OFF;
      endcase
   end

   // [R03] period scaling
   // [R17] duty times period
   // A negative duty is treated as zero rather than a huge on-time.
   always_comb begin
      per_prod = PER16 * mfunc_q;
      act_calc = (per_prod[30:15] == 16'h0) ? 16'h1 : per_prod[30:15];
      duty_pos = duty_q[15] ? 16'h0 : duty_q; // [R02] negative clamp
      cmp_prod = duty_pos * act_calc;
      cmp_calc = cmp_prod[30:15];
   end

   // [R15] updates need init
   // [R16] shadow load on request
   // A request landing on a load cycle stays pending, so none is lost.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pend_q    <= 1'b0;
         sh_action_control_word_q <= `BCP_ACTION_CONTROL_WORD_OFF;
         sh_act_q  <= 16'h1;
         sh_cmp_q  <= 16'h0;
         sh_idx_q  <= 3'h0;
      end else if (upd && mode_q == bcp_pkg::BCP_RUN) begin
         pend_q    <= 1'b1;
         sh_action_control_word_q <= action_control_word_calc;
         sh_act_q  <= act_calc;
         sh_cmp_q  <= cmp_calc;
         sh_idx_q  <= idx_q;
      end else if (load || mode_q != bcp_pkg::BCP_RUN) begin
         pend_q <= 1'b0;
      end
   end

   // [R04] period counter wrap
   assign wrap = cnt_q >= act_q - 16'h1;
   assign load = pend_q && wrap && mode_q == bcp_pkg::BCP_RUN;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 16'h0;
      end else if (mode_q != bcp_pkg::BCP_RUN || wrap) begin
         cnt_q <= 16'h0;
      end else begin
         cnt_q <= cnt_q + 16'h1;
      end
   end

   // [R18] three compare channels
   // New settings take effect only at a period boundary to avoid runt pulses.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         action_control_word_q    <= `BCP_ACTION_CONTROL_WORD_OFF;
         act_q     <= PER16;
         cur_idx_q <= 3'h0;
         for (int c = 0; c < 3; c++) begin
            cmp_q[c] <= 16'h0;
         end
      end else if (mode_q != bcp_pkg::BCP_RUN) begin
         action_control_word_q <= `BCP_ACTION_CONTROL_WORD_OFF;
      end else if (load) begin
         action_control_word_q    <= sh_action_control_word_q;
         act_q     <= sh_act_q;
         cur_idx_q <= sh_idx_q;
         for (int c = 0; c < 3; c++) begin
            cmp_q[c] <= sh_cmp_q;
         end
      end
   end

   // [R08] action field decode
   // Each pair of outputs shares one compare channel.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         unique case (action_control_word_q[2*i +: 2])
            `BCP_ACT_LOW:  gate_d[i] = 1'b0;
            `BCP_ACT_ALO:  gate_d[i] = !(cnt_q < cmp_q[i/2]);
            `BCP_ACT_AHI:  gate_d[i] = cnt_q < cmp_q[i/2];
            `BCP_ACT_HIGH: gate_d[i] = 1'b1;
         endcase
      end
   end

   // [R05] six registered gates
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gate_q <= 6'h0;
      end else begin
         gate_q <= gate_d;
      end
   end

   assign gate_output_n = gate_q;
   assign hrdata        = rdata_q;
   assign hreadyout     = rdy_q;
   assign hresp         = 1'b0;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   chk_two_active: assert property ($countones(gate_q) <= 2) // [R07]
      else $error("more than two gates on");
   chk_state0_word: assert property (load && sh_idx_q == 3'd0 |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_S0) // [R09]
      else $error("state 0 word wrong");
   chk_state1_word: assert property (load && sh_idx_q == 3'd1 |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_S1) // [R10]
      else $error("state 1 word wrong");
   chk_state2_word: assert property (load && sh_idx_q == 3'd2 |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_S2) // [R11]
      else $error("state 2 word wrong");
   chk_state3_word: assert property (load && sh_idx_q == 3'd3 |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_S3) // [R12]
      else $error("state 3 word wrong");
   chk_state4_word: assert property (load && sh_idx_q == 3'd4 |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_S4) // [R13]
      else $error("state 4 word wrong");
   chk_state5_word: assert property (load && sh_idx_q == 3'd5 |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_S5) // [R14]
      else $error("state 5 word wrong");
   chk_update_needs_init: assert property (mode_q != bcp_pkg::BCP_RUN |=> !pend_q) // [R15]
      else $error("update accepted before init");
   chk_compare_bound: assert property (cmp_q[0] < act_q && cmp_q[1] == cmp_q[0]) // [R17]
      else $error("compare outside period");
   chk_counter_range: assert property (cnt_q < act_q) // [R04]
      else $error("counter beyond period");
   chk_lower_on: assert property (action_control_word_q[7:6] == `BCP_ACT_HIGH && $stable(action_control_word_q)
      |=> gate_q[3]) // [R08]
      else $error("lower switch 4 not held on");

   // The checks below guard the state table and the update path as a whole, so that a
   // broken decode shows up even where the bench does not look at that cycle.

   // [R01] illegal index parks
   chk_illegal_off: assert property (load && sh_idx_q > 3'd5 |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_OFF) // [R01]
      else $error("illegal index did not park gates");

   // [R03] period floor of one
   chk_period_floor: assert property (upd && mode_q == bcp_pkg::BCP_RUN && mfunc_q == 16'h0
      |=> sh_act_q == 16'h1) // [R03]
      else $error("zero modulation did not floor period");

   // [R04] period never above constant
   chk_period_max: assert property (act_q <= PER16) // [R04]
      else $error("active period above constant");

   // [R06] no leg shorted
   chk_leg_short: assert property ((gate_q & (gate_q >> 1) & 6'h15) == 6'h00) // [R06]
      else $error("both switches of a leg on");

   // [R07] two active fields
   chk_two_fields: assert property (load && sh_idx_q < 3'd6 |=> $countones({|action_control_word_q[1:0],
      |action_control_word_q[3:2], |action_control_word_q[5:4], |action_control_word_q[7:6], |action_control_word_q[9:8], |action_control_word_q[11:10]}) == 2) // [R07]
      else $error("active field count not two");

   // [R08] upper never fully on
   chk_upper_pwm: assert property (action_control_word_q[1:0] != `BCP_ACT_HIGH && action_control_word_q[5:4] != `BCP_ACT_HIGH
      && action_control_word_q[9:8] != `BCP_ACT_HIGH) // [R08]
      else $error("upper switch held fully on");

   // [R08] lower never active-high modulated
   chk_lower_static: assert property (action_control_word_q[3:2] != `BCP_ACT_AHI && action_control_word_q[7:6] != `BCP_ACT_AHI
      && action_control_word_q[11:10] != `BCP_ACT_AHI) // [R08]
      else $error("lower switch modulated");

   // [R15] outputs parked without init
   chk_off_uninit: assert property (mode_q != bcp_pkg::BCP_RUN |=> action_control_word_q == `BCP_ACTION_CONTROL_WORD_OFF) // [R15]
      else $error("action word live without init");

   // [R16] request sets pending
   chk_update_pend: assert property (upd && mode_q == bcp_pkg::BCP_RUN |=> pend_q) // [R16]
      else $error("update request not pending");

   // [R16] load clears pending
   chk_load_clear: assert property (load && !(upd && mode_q == bcp_pkg::BCP_RUN) |=> !pend_q) // [R16]
      else $error("pending not cleared by load");

   // [R17] zero duty gives zero compare
   chk_zero_duty: assert property (upd && mode_q == bcp_pkg::BCP_RUN && duty_q == 16'h0
      |=> sh_cmp_q == 16'h0) // [R17]
      else $error("zero duty gave nonzero compare");

   // [R18] gate follows compare
   chk_gate_cmp: assert property (action_control_word_q[1:0] == `BCP_ACT_AHI
      |=> gate_q[0] == $past(cnt_q < cmp_q[0])) // [R18]
      else $error("switch 1 does not follow compare");

endmodule : bcp_commutation_pwm

// ==== bcp_gate_model.sv ====
`timescale 1ns/1ns
// Gate drive stage of the bridge; it only flags a leg driven high on both switches.
module bcp_gate_model (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // Gate levels from the block.
   input  wire logic [5:0] gate_output_n,
   // Sticky shoot-through flag.
   output logic            shoot_q
);
   // legs never shorted
   // Legs pair switches 1-2, 3-4 and 5-6; a shorted leg would destroy the bridge.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         shoot_q <= 1'b0;
      end else if ((gate_output_n & (gate_output_n >> 1) & 6'h15) != 6'h00) begin
         shoot_q <= 1'b1;
      end
   end
endmodule : bcp_gate_model

// ==== bcp_map.svh ====
`ifndef BCP_MAP_SVH
`define BCP_MAP_SVH

// Register byte offsets on the bus.
`define BCP_OFS_CTRL    8'h00
`define BCP_OFS_STATE   8'h04
`define BCP_OFS_DUTY    8'h08
`define BCP_OFS_MFUNC   8'h0c
`define BCP_OFS_UPDATE  8'h10
`define BCP_OFS_STATUS  8'h14
`define BCP_OFS_CMP1    8'h18
`define BCP_OFS_CMP2    8'h1c
`define BCP_OFS_CMP3    8'h20
`define BCP_OFS_PERIOD  8'h24

// Field positions.
`define BCP_CTRL_INIT_BIT  0
`define BCP_UPD_REQ_BIT    0
`define BCP_STAT_PEND_BIT  15

// Reset values.
`define BCP_STATE_RST  3'h0
`define BCP_Q15_RST    16'h0000
`define BCP_MFUNC_RST  16'h7fff

// Action control words, two bits for each gate output, output 1 lowest.
`define BCP_ACTION_CONTROL_WORD_S0   12'h0c2
`define BCP_ACTION_CONTROL_WORD_S1   12'hc02
`define BCP_ACTION_CONTROL_WORD_S2   12'hc20
`define BCP_ACTION_CONTROL_WORD_S3   12'h02c
`define BCP_ACTION_CONTROL_WORD_S4   12'h20c
`define BCP_ACTION_CONTROL_WORD_S5   12'h2c0
`define BCP_ACTION_CONTROL_WORD_OFF  12'h000

// Action field codes.
`define BCP_ACT_LOW   2'h0
`define BCP_ACT_ALO   2'h1
`define BCP_ACT_AHI   2'h2
`define BCP_ACT_HIGH  2'h3

// Timing: clock rate and switching frequency in hertz.
`define BCP_SYS_CLK_HZ   125000000
`define BCP_PWM_FREQ_HZ  20000
`define BCP_PERIOD_CYC   (`BCP_SYS_CLK_HZ / `BCP_PWM_FREQ_HZ)

`endif

// ==== bcp_pkg.sv ====
package bcp_pkg;
   typedef logic [11:0] bcp_action_control_word_t;
   typedef logic [15:0] bcp_q15_t;
   typedef enum logic [0:0] {BCP_UNINIT, BCP_RUN} bcp_mode_t;
endpackage : bcp_pkg

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
   localparam int PC = 20;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [5:0]  gate_output_n;
   logic        shoot_q;
   logic [31:0] r;
   int          mismatches = 0;
   int          checked = 0;
   int          seed = 71805;
   int          hc[6];
   int          p, c, st, d, m, k, f;

   bcp_commutation_pwm #(.PERIOD_CYC(PC)) bcp_commutation_pwm_inst (.sys_clk(sys_clk),
      .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .gate_output_n(gate_output_n));
   bcp_gate_model bcp_gate_model_inst (.sys_clk(sys_clk), .resetn(resetn),
      .gate_output_n(gate_output_n), .shoot_q(shoot_q));

   // Clock of 8 ns period.
   always #4 sys_clk = ~sys_clk;

   // Expected action word of each state index; illegal indices switch all off.
   function automatic logic [11:0] exp_act(input int s);
      case (s)
         0: exp_act = 12'h0c2;
         1: exp_act = 12'hc02;
         2: exp_act = 12'hc20;
         3: exp_act = 12'h02c;
         4: exp_act = 12'h20c;
         5: exp_act = 12'h2c0;
         default: exp_act = 12'h000;
      endcase
   endfunction : exp_act

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One single AHB-Lite transfer; the wait on hready is cut only by the watchdog.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   // Counts high cycles of each gate over one whole active period.
   task automatic meas(input int n);
      hc = '{default: 0};
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         for (int i = 0; i < 6; i++) hc[i] += gate_output_n[i];
      end
   endtask : meas

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      close_out();
   end

   // Main sequence: every state index, duty and period corners, then random values.
   initial begin
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      bus(1'b1, 8'h08, 32'h4000);
      bus(1'b1, 8'h10, 32'h1);
      repeat (45) @(posedge sys_clk);
      #1;
      chk("gates_uninit", 32'h0, {26'h0, gate_output_n});
      bus(1'b1, 8'h00, 32'h1);
      for (k = 0; k < 16; k++) begin
         st = k % 8;
         d = (k == 0) ? 32'h7fff : (k == 1) ? 0 : ($random(seed) & 32'h7fff);
         m = (k < 8) ? 32'h7fff : (k == 8) ? 0 : ($random(seed) & 32'h7fff);
         bus(1'b1, 8'h04, st);
         bus(1'b1, 8'h08, d);
         bus(1'b1, 8'h0c, m);
         bus(1'b1, 8'h10, 32'h1);
         repeat (45) @(posedge sys_clk);
         p = (PC * m) >>> 15;
         if (p < 1) p = 1;
         c = (d * p) >>> 15;
         bus(1'b0, 8'h24, 32'h0);
         chk("period", p, r);
         bus(1'b0, 8'h18, 32'h0);
         chk("compare1", c, r);
         bus(1'b0, 8'h14, 32'h0);
         chk("status", {16'h0, 1'b0, st[2:0], exp_act(st)}, r);
         chk("hresp", 32'h0, {31'h0, hresp});
         meas(p);
         for (int i = 0; i < 6; i++) begin
            f = (exp_act(st) >> (2 * i)) & 3;
            chk("gate_high", (f == 3) ? p : (f == 2) ? c : 0, hc[i]);
         end
      end
      chk("shoot", 32'h0, {31'h0, shoot_q});
      bus(1'b1, 8'h00, 32'h0);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("gates_off", 32'h0, {26'h0, gate_output_n});
      close_out();
   end
endmodule : testbench
